// File: hdl/vc_capability_and_port_clock_regs.sv
`timescale 1ns/1ns
`include "vc_regs_map.svh"
module vc_capability_and_port_clock_regs
   import vc_regs_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // Host configuration access
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [1:0] i_cfg_port,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic [3:0] i_cfg_be,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_rd_valid,
   // Serial EEPROM / I2C loader writes
   input wire logic i_load_wr,
   input wire logic [1:0] i_load_port,
   input wire logic [11:0] i_load_addr,
   input wire logic [31:0] i_load_data,
   // Port layout strap pin
   input wire logic i_port_layout_strap,
   // Per-port events from the link and hot-plug logic
   input wire logic [3:0] i_vc_neg_done,
   input wire logic [3:0] i_hp_irq_req,
   input wire logic [3:0] i_gpio_irq_req,
   output logic [3:0] o_intx_msg_req,
   output logic o_legacy_irq_pin_n,
   // Clock gating
   output logic [3:0] o_port_domain_a_clock_enable,
   output logic [3:0] o_int_port_clock_enable,
   output logic [2:0] o_refclk_out_enable,
   output logic [3:0] o_port_enable
);

   bank_state_t st;
   bank_state_t next_st;
   logic [3:0] hp_pin_sel;
   logic [3:0] gpio_pin_sel;
   logic [31:0] port_rdata [4];
   logic bus_ld;
   logic bus_wr;
   logic [1:0] bus_port;
   logic [11:0] bus_addr;
   logic [31:0] bus_wdata;
   logic [3:0] bus_be;
   logic [31:0] gate_merge;
   logic [31:0] read_value;

   // Enable mask for ports 1 to 3 under a given layout
   function automatic logic [2:0] port_mask(input logic layout);
      port_mask = layout ? `PORT_MASK_STRAP1 : `PORT_MASK_STRAP0;
   endfunction : port_mask

   // ****************************************
   // Shared write path
   // ****************************************
   // Loader has priority; a host write in the same cycle is dropped
   assign bus_ld = i_load_wr;
   assign bus_wr = i_cfg_wr & ~i_load_wr;
   assign bus_port = i_load_wr ? i_load_port : i_cfg_port;
   assign bus_addr = i_load_wr ? i_load_addr : i_cfg_addr;
   assign bus_wdata = i_load_wr ? i_load_data : i_cfg_wdata;
   assign bus_be = i_load_wr ? 4'hF : i_cfg_be;

   // ****************************************
   // Per-port channel register sets
   // ****************************************
   // One full copy per port, upstream port 0 differs only in its pointer
   for (genvar g = 0; g < 4; g++) begin : g_port
      vc_port_if vc_bus ();
      assign vc_bus.sel = (bus_port == 2'(g));
      assign vc_bus.wr = bus_wr;
      assign vc_bus.ld = bus_ld;
      assign vc_bus.addr = bus_addr;
      assign vc_bus.rd_addr = i_cfg_addr;
      assign vc_bus.wdata = bus_wdata;
      assign vc_bus.be = bus_be;
      assign vc_bus.neg_done = i_vc_neg_done[g];
      assign port_rdata[g] = vc_bus.rdata;
      assign hp_pin_sel[g] = vc_bus.hp_pin;
      assign gpio_pin_sel[g] = vc_bus.gpio_pin;
      vc_port_regs #(
         .UPSTREAM(g == 0)
      ) u_port (
         .i_clock(i_clock),
         .i_sys_rst(i_sys_rst),
         .bus(vc_bus.port)
      );
   end

   // ****************************************
   // Read mux
   // ****************************************
   // Clock gating and port layout live in port 0 only; other hits read zero
   always_comb begin
      read_value = port_rdata[i_cfg_port];
      if (addr_is(i_cfg_addr, `CLK_GATE_OFS)) begin
         read_value = (i_cfg_port == 2'h0) ? {21'h0, st.clk_gate} : 32'h0;
      end else if (addr_is(i_cfg_addr, `PORT_CFG_OFS)) begin
         read_value = (i_cfg_port == 2'h0) ? {31'h0, st.layout} : 32'h0;
      end
   end

   assign gate_merge = merge_bytes({21'h0, st.clk_gate}, i_cfg_wdata, i_cfg_be);

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      next_st = st;
      // Strap pin passes two flops before anything looks at it
      next_st.strap_meta = i_port_layout_strap;
      next_st.strap_sync = st.strap_meta;

      // Strap capture sequence after reset release
      case (st.phase)
         PH_SETTLE: begin
            next_st.settle = st.settle + 2'h1;
            if (st.settle == `STRAP_SETTLE - 2'h1) begin
               next_st.phase = PH_APPLY;
            end
         end
         PH_APPLY: begin
            // A layout already loaded overrides the pin
            if (!st.override) begin
               next_st.layout = st.strap_sync;
               next_st.clk_gate[`CLK_DOM_A_LSB + 1 +: 3] = port_mask(st.strap_sync);
               next_st.clk_gate[`CLK_INT_LSB + 1 +: 3] = port_mask(st.strap_sync);
            end
            next_st.phase = PH_RUN;
         end
         PH_RUN: begin
            next_st.phase = PH_RUN;
         end
         default: begin
            next_st.phase = PH_RUN;
         end
      endcase

      // Clock gating writes, port 0 only, reserved bits dropped
      if (bus_ld && bus_port == 2'h0 && addr_is(bus_addr, `PORT_CFG_OFS)) begin
         next_st.override = 1'b1;
         next_st.layout = bus_wdata[0];
         next_st.clk_gate[`CLK_DOM_A_LSB + 1 +: 3] = port_mask(bus_wdata[0]);
         next_st.clk_gate[`CLK_INT_LSB + 1 +: 3] = port_mask(bus_wdata[0]);
      end else if (bus_ld && bus_port == 2'h0 && addr_is(bus_addr, `CLK_GATE_OFS)) begin
         next_st.clk_gate = bus_wdata[10:0];
      end else if (bus_wr && bus_port == 2'h0 && addr_is(bus_addr, `CLK_GATE_OFS)) begin
         next_st.clk_gate = gate_merge[10:0];
      end

      // Read answer one cycle after the request
      next_st.rd_valid = i_cfg_rd;
      next_st.rdata = i_cfg_rd ? read_value : 32'h0;

      // Route each request to a message or to the shared pin
      next_st.intx_msg = (i_hp_irq_req & ~hp_pin_sel) | (i_gpio_irq_req & ~gpio_pin_sel);
      next_st.irq_pin_n = ~|((i_hp_irq_req & hp_pin_sel) | (i_gpio_irq_req & gpio_pin_sel));

      // A port runs while either of its clock enables is set; port 0 cannot drop
      next_st.port_en = next_st.clk_gate[`CLK_DOM_A_LSB +: 4] | next_st.clk_gate[`CLK_INT_LSB +: 4];
      next_st.port_en[0] = 1'b1;
   end

   // State register
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '{phase: PH_SETTLE, settle: 2'h0, strap_meta: 1'b0, strap_sync: 1'b0, layout: 1'b0,
                 override: 1'b0, clk_gate: `CLK_GATE_RST, rdata: 32'h0, rd_valid: 1'b0,
                 intx_msg: 4'h0, irq_pin_n: 1'b1, port_en: 4'h1};
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs, all straight from flops
   // ****************************************
   assign o_cfg_rdata = st.rdata;
   assign o_cfg_rd_valid = st.rd_valid;
   assign o_intx_msg_req = st.intx_msg;
   assign o_legacy_irq_pin_n = st.irq_pin_n;
   assign o_port_domain_a_clock_enable = st.clk_gate[`CLK_DOM_A_LSB +: 4];
   assign o_int_port_clock_enable = st.clk_gate[`CLK_INT_LSB +: 4];
   assign o_refclk_out_enable = st.clk_gate[10:8];
   assign o_port_enable = st.port_en;

endmodule : vc_capability_and_port_clock_regs

// File: hdl/vc_port_if.sv
`timescale 1ns/1ns
// Carries one port's share of the configuration traffic
interface vc_port_if;
   logic sel;
   logic wr;
   logic ld;
   logic [11:0] addr;
   logic [11:0] rd_addr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic neg_done;
   logic [31:0] rdata;
   logic hp_pin;
   logic gpio_pin;
   modport bank (output sel, wr, ld, addr, rd_addr, wdata, be, neg_done, input rdata, hp_pin, gpio_pin);
   modport port (input sel, wr, ld, addr, rd_addr, wdata, be, neg_done, output rdata, hp_pin, gpio_pin);
endinterface : vc_port_if

// File: hdl/vc_port_regs.sv
`timescale 1ns/1ns
`include "vc_regs_map.svh"
module vc_port_regs
   import vc_regs_pkg::*;
#(
   parameter bit UPSTREAM = 1'b0
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   vc_port_if.port bus
);

   port_state_t st;
   port_state_t next_st;
   logic [31:0] old_word;

   // Read value of one register; reserved bits come back zero
   function automatic logic [31:0] read_word(input logic [11:0] a, input port_state_t s);
      read_word = 32'h0;
      if (addr_is(a, `VC_HDR_OFS)) begin
         read_word = {(UPSTREAM ? `VC_NEXT_UP : `VC_NEXT_DN), `VC_CAP_VER, `VC_CAP_ID};
      end else if (addr_is(a, `VC_CAP1_OFS)) begin
         read_word = {20'h0, `VC_ENTRY_SIZE, 3'h0, `VC_LP_COUNT, 1'h0, `VC_EXT_COUNT};
      end else if (addr_is(a, `VC_CAP2_OFS)) begin
         read_word = {31'h0, `VC_LP_RR_CAP};
      end else if (addr_is(a, `VC_STCTL_OFS)) begin
         read_word = {28'h0, s.arb_sel, 1'h0};
      end else if (addr_is(a, `VC0_CAP_OFS)) begin
         read_word = {`VC0_ARB_TBL_OFS, 8'h0, 1'h0, 7'h0, `VC0_PORT_ARB_CAP};
      end else if (addr_is(a, `VC0_CTL_OFS)) begin
         read_word = {1'h1, 4'h0, `VC0_ID, 16'h0, s.tc_map, 1'h1};
      end else if (addr_is(a, `VC0_STS_OFS)) begin
         read_word = {14'h0, s.neg_pending, 1'h0, 16'h0};
      end else if (addr_is(a, `IRQ_ROUTE_OFS)) begin
         read_word = {21'h0, s.route};
      end
   endfunction : read_word

   // ****************************************
   // Next-state logic
   // ****************************************
   // Loader writes may reach fields software cannot; host writes honour byte lanes
   always_comb begin
      next_st = st;
      old_word = merge_bytes(read_word(bus.addr, st), bus.wdata, bus.be);
      if (bus.sel && bus.ld) begin
         if (addr_is(bus.addr, `VC_STCTL_OFS)) begin
            next_st.arb_sel = bus.wdata[`ARB_SEL_LSB +: 3];
         end else if (addr_is(bus.addr, `VC0_CTL_OFS)) begin
            next_st.tc_map = bus.wdata[`TC_MAP_LSB +: 7];
         end else if (addr_is(bus.addr, `VC0_STS_OFS)) begin
            next_st.neg_pending = bus.wdata[`STS_PEND_BIT];
         end else if (addr_is(bus.addr, `IRQ_ROUTE_OFS)) begin
            next_st.route = bus.wdata[10:0];
         end
      end else if (bus.sel && bus.wr) begin
         if (addr_is(bus.addr, `VC_STCTL_OFS)) begin
            next_st.arb_sel = old_word[`ARB_SEL_LSB +: 3];
         end else if (addr_is(bus.addr, `VC0_CTL_OFS)) begin
            next_st.tc_map = old_word[`TC_MAP_LSB +: 7];
         end else if (addr_is(bus.addr, `IRQ_ROUTE_OFS)) begin
            next_st.route[9:0] = old_word[9:0];
            // Write-one-to-clear flag on the second byte lane
            next_st.route[`ROUTE_FLAG_BIT] = st.route[`ROUTE_FLAG_BIT] &
                                             ~(bus.be[1] & bus.wdata[`ROUTE_FLAG_BIT]);
         end
      end
      // Completion of negotiation always wins over a loaded value
      if (bus.neg_done) begin
         next_st.neg_pending = 1'b0;
      end
   end

   // State register
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= '{arb_sel: `VC_ARB_SEL_RST, tc_map: `VC0_TC_MAP_RST, neg_pending: 1'b1, route: `ROUTE_RST};
      end else begin
         st <= next_st;
      end
   end

   assign bus.rdata = read_word(bus.rd_addr, st);
   assign bus.hp_pin = st.route[`ROUTE_HP_BIT];
   assign bus.gpio_pin = st.route[`ROUTE_GPIO_BIT];

endmodule : vc_port_regs

// File: hdl/vc_regs_map.svh
`ifndef VC_REGS_MAP_SVH
`define VC_REGS_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define VC_HDR_OFS 12'h148
`define VC_CAP1_OFS 12'h14C
`define VC_CAP2_OFS 12'h150
`define VC_STCTL_OFS 12'h154
`define VC0_CAP_OFS 12'h158
`define VC0_CTL_OFS 12'h15C
`define VC0_STS_OFS 12'h160
`define IRQ_ROUTE_OFS 12'h1C8
`define CLK_GATE_OFS 12'h1D8
`define PORT_CFG_OFS 12'h574

// ****************************************
// Fixed field values and reset values
// ****************************************
`define VC_CAP_ID 16'h0002
`define VC_CAP_VER 4'h1
`define VC_NEXT_UP 12'h950
`define VC_NEXT_DN 12'h520
`define VC_EXT_COUNT 3'h0
`define VC_LP_COUNT 3'h0
`define VC_ENTRY_SIZE 2'h0
`define VC_LP_RR_CAP 1'h0
`define VC_ARB_SEL_RST 3'h0
`define VC0_PORT_ARB_CAP 8'h01
`define VC0_ARB_TBL_OFS 8'h00
`define VC0_TC_MAP_RST 7'h7F
`define VC0_ID 3'h0
`define ROUTE_RST 11'h000
`define CLK_GATE_RST 11'h711

// ****************************************
// Field positions
// ****************************************
`define ARB_SEL_LSB 1
`define TC_MAP_LSB 1
`define STS_PEND_BIT 17
`define ROUTE_HP_BIT 4
`define ROUTE_GPIO_BIT 6
`define ROUTE_FLAG_BIT 10
`define CLK_DOM_A_LSB 0
`define CLK_INT_LSB 4

// ****************************************
// Strap handling
// ****************************************
`define STRAP_SETTLE 2'h2
`define PORT_MASK_STRAP0 3'h7
`define PORT_MASK_STRAP1 3'h3

`endif

// File: hdl/vc_regs_pkg.sv
package vc_regs_pkg;

   // ****************************************
   // State types
   // ****************************************
   typedef enum logic [1:0] {PH_SETTLE, PH_APPLY, PH_RUN} bank_phase_t;

   typedef struct packed {
      logic [2:0] arb_sel;
      logic [6:0] tc_map;
      logic neg_pending;
      logic [10:0] route;
   } port_state_t;

   typedef struct packed {
      bank_phase_t phase;
      logic [1:0] settle;
      logic strap_meta;
      logic strap_sync;
      logic layout;
      logic override;
      logic [10:0] clk_gate;
      logic [31:0] rdata;
      logic rd_valid;
      logic [3:0] intx_msg;
      logic irq_pin_n;
      logic [3:0] port_en;
   } bank_state_t;

   // Dword offset compare; the two low address bits are ignored
   function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] ofs);
      addr_is = (addr[11:2] == ofs[11:2]);
   endfunction : addr_is

   // Byte-lane merge of a write into the current word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wdata,
                                               input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         merge_bytes[i*8 +: 8] = be[i] ? wdata[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge_bytes

endpackage : vc_regs_pkg

// File: verif/test_vc_capability_and_port_clock_regs.sv
`timescale 1ns/1ns
module test_vc_capability_and_port_clock_regs;
   logic i_clock = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_cfg_wr = 1'b0;
   logic i_cfg_rd = 1'b0;
   logic [1:0] i_cfg_port = 2'h0;
   logic [11:0] i_cfg_addr = 12'h000;
   logic [31:0] i_cfg_wdata = 32'h0;
   logic [3:0] i_cfg_be = 4'h0;
   logic i_port_layout_strap = 1'b0;
   logic [3:0] i_vc_neg_done = 4'h0;
   logic [3:0] i_hp_irq_req = 4'h0;
   logic [3:0] i_gpio_irq_req = 4'h0;
   logic ld_go = 1'b0;
   logic [1:0] ld_port = 2'h0;
   logic [11:0] ld_addr = 12'h000;
   logic [31:0] ld_data = 32'h0;
   logic i_load_wr, o_cfg_rd_valid, o_legacy_irq_pin_n;
   logic [1:0] i_load_port;
   logic [11:0] i_load_addr;
   logic [31:0] i_load_data, o_cfg_rdata, d;
   logic [3:0] o_intx_msg_req, o_port_domain_a_clock_enable, o_int_port_clock_enable, o_port_enable;
   logic [2:0] refclk;
   logic [31:0] exp_q[$];
   logic [11:0] offs [10] = '{12'h148, 12'h14C, 12'h150, 12'h154, 12'h158, 12'h15C, 12'h160, 12'h1C8, 12'h1D8, 12'h200};
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #2 i_clock = ~i_clock;

   vc_capability_and_port_clock_regs dut (.i_clock, .i_sys_rst, .i_cfg_wr, .i_cfg_rd, .i_cfg_port, .i_cfg_addr,
      .i_cfg_wdata, .i_cfg_be, .o_cfg_rdata, .o_cfg_rd_valid, .i_load_wr, .i_load_port, .i_load_addr, .i_load_data,
      .i_port_layout_strap, .i_vc_neg_done, .i_hp_irq_req, .i_gpio_irq_req, .o_intx_msg_req, .o_legacy_irq_pin_n,
      .o_port_domain_a_clock_enable, .o_int_port_clock_enable, .o_refclk_out_enable(refclk), .o_port_enable);
   vc_loader_model loader (.i_clock, .i_go(ld_go), .i_port(ld_port), .i_addr(ld_addr), .i_data(ld_data),
      .o_load_wr(i_load_wr), .o_load_port(i_load_port), .o_load_addr(i_load_addr), .o_load_data(i_load_data));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // Each read answer is matched against the oldest expectation, mid-cycle while it stands
   always @(negedge i_clock) begin
      if (o_cfg_rd_valid === 1'b1) begin
         if (exp_q.size() > 0) check(o_cfg_rdata, exp_q.pop_front());
         else check({31'h0, o_cfg_rd_valid}, 32'h0);
      end
   end

   // Hang guard; a full run needs well under a thousand cycles
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         tally_and_finish();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : tick

   task automatic rd(input logic [1:0] p, input logic [11:0] a, input logic [31:0] e);
      tick(1);
      i_cfg_rd = 1'b1;
      i_cfg_port = p;
      i_cfg_addr = a;
      exp_q.push_back(e);
      tick(1);
      i_cfg_rd = 1'b0;
   endtask : rd

   task automatic wr(input logic [1:0] p, input logic [11:0] a, input logic [31:0] v, input logic [3:0] be);
      tick(1);
      i_cfg_wr = 1'b1;
      i_cfg_port = p;
      i_cfg_addr = a;
      i_cfg_wdata = v;
      i_cfg_be = be;
      tick(1);
      i_cfg_wr = 1'b0;
   endtask : wr

   task automatic load(input logic [1:0] p, input logic [11:0] a, input logic [31:0] v);
      tick(1);
      ld_go = 1'b1;
      ld_port = p;
      ld_addr = a;
      ld_data = v;
      tick(1);
      ld_go = 1'b0;
      tick(2);
   endtask : load

   // Reset contents per port and offset index
   function automatic logic [31:0] rst_val(input int p, input int i, input logic s);
      case (i)
         0: return (p == 0) ? 32'h9501_0002 : 32'h5201_0002;
         4: return 32'h0000_0001;
         5: return 32'h8000_00FF;
         6: return 32'h0002_0000;
         8: return (p != 0) ? 32'h0 : (s ? 32'h0000_0777 : 32'h0000_07FF);
         default: return 32'h0;
      endcase
   endfunction : rst_val

   task automatic reset_and_scan(input logic s);
      i_port_layout_strap = s;
      i_sys_rst = 1'b1;
      tick(20);
      i_sys_rst = 1'b0;
      tick(5);
      check({28'h0, o_port_enable}, s ? 32'h7 : 32'hF);
      check({29'h0, refclk}, 32'h7);
      for (int p = 0; p < 4; p++) begin
         for (int i = 0; i < 10; i++) rd(p[1:0], offs[i], rst_val(p, i, s));
      end
      $display("test reset scan with strap %0d done", s);
   endtask : reset_and_scan

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(35249));
      reset_and_scan(1'b0);
      d = $urandom;
      wr(1, 12'h148, d, 4'hF);
      rd(1, 12'h148, 32'h5201_0002);
      wr(1, 12'h15C, d, 4'hF);
      rd(1, 12'h15C, {8'h80, 16'h0, d[7:1], 1'b1});
      wr(1, 12'h15C, ~d, 4'hE);
      rd(1, 12'h15C, {8'h80, 16'h0, d[7:1], 1'b1});
      wr(2, 12'h154, d & 32'hFFFF_FFF1, 4'hF);
      rd(2, 12'h154, 32'h0);
      load(3, 12'h15C, 32'h0);
      rd(3, 12'h15C, 32'h8000_0001);
      $display("test read-only and class map done");
      // Every routing choice, each request kind on its own
      for (int k = 0; k < 4; k++) begin
         wr(1, 12'h1C8, {25'h0, k[1], 1'b0, k[0], 4'h0}, 4'h1);
         rd(1, 12'h1C8, {25'h0, k[1], 1'b0, k[0], 4'h0});
         i_hp_irq_req[1] = 1'b1;
         tick(2);
         check({27'h0, o_legacy_irq_pin_n, o_intx_msg_req}, {27'h0, !k[0], 2'h0, !k[0], 1'b0});
         i_hp_irq_req[1] = 1'b0;
         i_gpio_irq_req[1] = 1'b1;
         tick(2);
         check({27'h0, o_legacy_irq_pin_n, o_intx_msg_req}, {27'h0, !k[1], 2'h0, !k[1], 1'b0});
         i_gpio_irq_req[1] = 1'b0;
      end
      // Loader sets the one-to-clear flag, a host write of one on lane 1 clears it
      load(1, 12'h1C8, 32'h0000_0400);
      rd(1, 12'h1C8, 32'h0000_0400);
      wr(1, 12'h1C8, 32'h0000_0400, 4'h2);
      rd(1, 12'h1C8, 32'h0);
      $display("test interrupt routing done");
      i_vc_neg_done[2] = 1'b1;
      tick(2);
      i_vc_neg_done[2] = 1'b0;
      rd(2, 12'h160, 32'h0);
      rd(3, 12'h160, 32'h0002_0000);
      $display("test negotiation pending done");
      wr(0, 12'h1D8, 32'h0000_07DD, 4'hF);
      tick(2);
      check({28'h0, o_port_enable}, 32'hD);
      rd(0, 12'h1D8, 32'h0000_07DD);
      wr(1, 12'h1D8, d, 4'hF);
      rd(1, 12'h1D8, 32'h0);
      load(0, 12'h574, 32'h1);
      check({28'h0, o_port_enable}, 32'h7);
      check({28'h0, o_port_domain_a_clock_enable}, 32'h7);
      check({28'h0, o_int_port_clock_enable}, 32'h7);
      $display("test clock gating and override done");
      reset_and_scan(1'b1);
      tick(3);
      check(exp_q.size(), 32'h0);
      tally_and_finish();
   end
endmodule : test_vc_capability_and_port_clock_regs

bind vc_capability_and_port_clock_regs vc_regs_properties props (.i_clock, .i_sys_rst, .i_cfg_rd, .i_cfg_port,
   .i_cfg_addr, .o_cfg_rdata, .o_cfg_rd_valid, .i_hp_irq_req, .i_gpio_irq_req, .o_intx_msg_req, .o_legacy_irq_pin_n,
   .o_port_domain_a_clock_enable, .o_int_port_clock_enable, .o_port_enable);

// File: verif/vc_loader_model.sv
`timescale 1ns/1ns
// Serial loader model: one whole-dword write per request
module vc_loader_model (
   input wire logic i_clock,
   input wire logic i_go,
   input wire logic [1:0] i_port,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_data,
   output logic o_load_wr,
   output logic [1:0] o_load_port,
   output logic [11:0] o_load_addr,
   output logic [31:0] o_load_data
);
   initial begin
      o_load_wr = 1'b0;
      o_load_port = 2'h0;
      o_load_addr = 12'h000;
      o_load_data = 32'h0;
   end
   // Word as software may send it: arbitration select zero, port 0 domain A clock kept on
   function automatic logic [31:0] legal_data(input logic [1:0] p, input logic [11:0] a, input logic [31:0] v);
      legal_data = v;
      if (a[11:2] == 10'h055) legal_data[3:1] = 3'h0;
      if (a[11:2] == 10'h076 && p == 2'h0) legal_data[0] = 1'b1;
   endfunction : legal_data

   // Released bus toggles so a stale word is never mistaken for a write
   always @(posedge i_clock) begin
      o_load_wr <= i_go;
      if (i_go) begin
         o_load_port <= i_port;
         o_load_addr <= i_addr;
         o_load_data <= legal_data(i_port, i_addr, i_data);
      end else begin
         o_load_port <= ~o_load_port;
         o_load_addr <= ~o_load_addr;
         o_load_data <= ~o_load_data;
      end
   end
endmodule : vc_loader_model

// File: verif/vc_regs_properties.sv
`timescale 1ns/1ns
// ****************************************
// Port-level checks of the register bank
// ****************************************
module vc_regs_properties (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_cfg_rd,
   input wire logic [1:0] i_cfg_port,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [31:0] o_cfg_rdata,
   input wire logic o_cfg_rd_valid,
   input wire logic [3:0] i_hp_irq_req,
   input wire logic [3:0] i_gpio_irq_req,
   input wire logic [3:0] o_intx_msg_req,
   input wire logic o_legacy_irq_pin_n,
   input wire logic [3:0] o_port_domain_a_clock_enable,
   input wire logic [3:0] o_int_port_clock_enable,
   input wire logic [3:0] o_port_enable
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   // Host read of one dword; low address bits do not matter
   sequence s_rd(logic [11:0] ofs);
      i_cfg_rd && (i_cfg_addr[11:2] == ofs[11:2]);
   endsequence

   // Answer whose masked bits hold a fixed value
   sequence s_ans(logic [31:0] mask, logic [31:0] val);
      o_cfg_rd_valid && ((o_cfg_rdata & mask) == val);
   endsequence

   chk_read_answer: assert property (i_cfg_rd |=> o_cfg_rd_valid)
      else $error("read not answered next cycle");
   chk_idle_rdata: assert property (!o_cfg_rd_valid |-> o_cfg_rdata == 32'h0)
      else $error("read data not zero while idle");
   chk_header_ident: assert property (s_rd(12'h148) |=> s_ans(32'h000F_FFFF, 32'h0001_0002))
      else $error("header identifier wrong");
   chk_next_pointer: assert property (s_rd(12'h148) |=>
      o_cfg_rdata[31:20] == (($past(i_cfg_port) == 2'h0) ? 12'h950 : 12'h520)) else $error("next pointer wrong");
   chk_cap_counts: assert property ((s_rd(12'h14C) or s_rd(12'h150)) |=> s_ans(32'hFFFF_FFFF, 32'h0))
      else $error("capability word not zero");
   chk_ctl_load_zero: assert property (s_rd(12'h154) |=> s_ans(32'hFFFF_FFF1, 32'h0))
      else $error("control word shows fixed bits set");
   chk_vc0_cap: assert property (s_rd(12'h158) |=> s_ans(32'hFFFF_FFFF, 32'h0000_0001))
      else $error("channel capability wrong");
   chk_vc0_ctl: assert property (s_rd(12'h15C) |=> s_ans(32'hFFFF_FF01, 32'h8000_0001))
      else $error("channel control fixed bits wrong");
   chk_vc0_status: assert property (s_rd(12'h160) |=> s_ans(32'hFFFD_FFFF, 32'h0))
      else $error("channel status fixed bits wrong");
   chk_port0_on: assert property (o_port_enable[0])
      else $error("port 0 disabled");
   chk_enable_follows: assert property (($stable(o_port_domain_a_clock_enable) && $stable(o_int_port_clock_enable))
      |-> o_port_enable[3:1] == (o_port_domain_a_clock_enable[3:1] | o_int_port_clock_enable[3:1]))
      else $error("port enable does not follow clock bits");
   chk_quiet_irq: assert property ((i_hp_irq_req == 4'h0 && i_gpio_irq_req == 4'h0)
      |=> (o_legacy_irq_pin_n && o_intx_msg_req == 4'h0)) else $error("interrupt without request");
endmodule : vc_regs_properties
